/* logic/wwd_top.sv */
// top: windowed watchdog register file, lock sequencer and outputs
//
// Decided for this implementation: the plain strobed port.
`default_nettype none

module wwd_top #(
    parameter logic [11:0] PART_NUM   = 12'h0a5, // arbitrary value
    parameter logic [3:0]  CONFIG_NUM = 4'h2,    // arbitrary value
    parameter logic [3:0]  MAJOR_REV  = 4'h3,    // arbitrary value
    parameter logic [3:0]  MINOR_REV  = 4'h0,    // arbitrary value
    parameter logic [7:0]  RSVD_NUM   = 8'h00    // arbitrary value
) (
    input  wire logic                      clk_i,       // system clock
    input  wire logic                      rst_i,       // async reset, high
    input  wire logic                      cnt_clk_i,   // counter clock pin
    input  wire logic [wwd_pkg::ADDR_W-1:0] addr_i,     // byte address
    input  wire logic [wwd_pkg::DATA_W-1:0] wdata_i,    // write data
    input  wire logic                      wr_i,        // write strobe
    input  wire logic                      rd_i,        // read strobe
    output logic      [wwd_pkg::DATA_W-1:0] rdata_o,    // read data
    output logic                           wdt_irq_o,   // timeout pulse
    output logic                           sys_rst_o,   // system reset pulse
    output logic                           early_irq_o, // early warning level
    output logic                           test_irq_o   // test flag level
);
    import wwd_pkg::*;

    ////////////////////////////////////////////////////////////////
    // state

    logic [7:0]  control_word;
    logic [15:0] load_value;
    logic [15:0] early_val;
    logic [15:0] win_val;
    logic [14:0] lock_code;
    logic [14:0] pend_code;
    logic        lock_active;
    logic        grant;
    wwd_seq_e    seq;
    logic        early_warning_flag;
    logic        test_flag;

    logic        watchdog_run_enable;
    logic        early_warning_irq_enable;
    logic        reload_window_enable;
    logic        test_enable;
    logic [3:0]  prescale_exponent;
    logic [13:0] count_snapshot;

    logic        lock_wr;
    logic        key_bit;
    logic [14:0] code_in;
    logic        unlock_hit;
    logic        prot_wr;
    logic        wr_ok;
    logic        load_wr;
    logic        win_viol;
    logic        sts_rd;
    logic        tick;

    wwd_cnt_if cnt ();

    ////////////////////////////////////////////////////////////////
    // field decode

    // control fields
    assign watchdog_run_enable      = control_word[CTRL_RUN];
    assign early_warning_irq_enable = control_word[CTRL_EWI];
    assign reload_window_enable     = control_word[CTRL_WIN];
    assign test_enable              = control_word[CTRL_TEST];
    assign prescale_exponent        = control_word[CTRL_EXP_HI:CTRL_EXP_LO];
    assign count_snapshot           = cnt.count[15:STS_CNT_LO];

    // bus decode
    assign lock_wr    = wr_i && (addr_i == ADDR_LOCK);
    assign key_bit    = wdata_i[LOCK_KEY];
    assign code_in    = wdata_i[14:0];
    assign unlock_hit = lock_wr && lock_active && !key_bit
                        && (code_in == lock_code);
    assign prot_wr    = wr_i && ((addr_i == ADDR_CTRL) || (addr_i == ADDR_LOAD)
                        || (addr_i == ADDR_EARLY) || (addr_i == ADDR_WIN));
    assign wr_ok      = prot_wr && (!lock_active || grant);
    assign load_wr    = wr_ok && (addr_i == ADDR_LOAD);
    assign sts_rd     = rd_i && (addr_i == ADDR_STS);

    // reload before the window opens: count still above boundary
    assign win_viol   = load_wr && reload_window_enable
                        && watchdog_run_enable && (cnt.count > win_val);

    ////////////////////////////////////////////////////////////////
    // counter hookup

    // counter clock pin into the system clock domain
    wwd_edge_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cnt_clk_i),
        .rise_o  (tick)
    );

    // reserved exponents above twelve act as twelve
    assign cnt.run       = watchdog_run_enable;
    assign cnt.tick      = tick;
    assign cnt.exp       = (prescale_exponent > EXP_MAX) ? EXP_MAX
                                                         : prescale_exponent;
    assign cnt.load_val  = load_value;
    assign cnt.early_val = early_val;

    wwd_counter u_counter (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cnt   (cnt.counter)
    );

    ////////////////////////////////////////////////////////////////
    // registers written by software

    // control word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_word <= CTRL_RESET;
        end else if (wr_ok && addr_i == ADDR_CTRL) begin
            control_word <= wdata_i[7:0];
        end
    end

    // load value, reload pulse follows the write
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_value <= LOAD_RESET;
            cnt.reload <= 1'b0;
        end else begin
            cnt.reload <= load_wr;
            if (load_wr) begin
                load_value <= wdata_i;
            end
        end
    end

    // early warning and window values
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            early_val <= EARLY_RESET;
            win_val   <= WIN_RESET;
        end else if (wr_ok) begin
            if (addr_i == ADDR_EARLY) begin
                early_val <= wdata_i;
            end
            if (addr_i == ADDR_WIN) begin
                win_val <= wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // lock code registration and single-write grant

    // key1, key0, key1 with one code registers it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq         <= WWD_SEQ_IDLE;
            pend_code   <= CODE_RESET;
            lock_code   <= CODE_RESET;
            lock_active <= 1'b0;
        end else if (lock_wr) begin
            unique case (seq)
                WWD_SEQ_IDLE: begin
                    if (key_bit) begin
                        seq       <= WWD_SEQ_KEY1;
                        pend_code <= code_in;
                    end
                end
                WWD_SEQ_KEY1: begin
                    if (key_bit) begin
                        pend_code <= code_in;
                    end else if (code_in == pend_code) begin
                        seq <= WWD_SEQ_KEY0;
                    end else begin
                        seq <= WWD_SEQ_IDLE;
                    end
                end
                WWD_SEQ_KEY0: begin
                    seq <= WWD_SEQ_IDLE;
                    if (key_bit && code_in == pend_code) begin
                        lock_code   <= pend_code;
                        lock_active <= 1'b1;
                    end
                end
                default: begin
                    seq <= WWD_SEQ_IDLE;
                end
            endcase
        end
    end

    // grant spans one write to any other register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            grant <= 1'b0;
        end else if (unlock_hit) begin
            grant <= 1'b1;
        end else if (wr_i && !lock_wr) begin
            grant <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // status flags, cleared by status read, set wins

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            early_warning_flag <= 1'b0;
        end else if (cnt.early && early_warning_irq_enable) begin
            early_warning_flag <= 1'b1;
        end else if (sts_rd) begin
            early_warning_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            test_flag <= 1'b0;
        end else if (!test_enable) begin
            test_flag <= 1'b0;
        end else if (cnt.expire) begin
            test_flag <= 1'b1;
        end else if (sts_rd) begin
            test_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs

    // timeout and window violation pulses, flag levels
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_irq_o   <= 1'b0;
            sys_rst_o   <= 1'b0;
            early_irq_o <= 1'b0;
            test_irq_o  <= 1'b0;
        end else begin
            wdt_irq_o   <= cnt.expire;
            sys_rst_o   <= cnt.expire || win_viol;
            early_irq_o <= early_warning_flag;
            test_irq_o  <= test_flag;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (!rd_i) begin
            rdata_o <= '0;
        end else begin
            unique case (addr_i)
                ADDR_CTRL:  rdata_o <= {8'h00, control_word};
                ADDR_STS:   rdata_o <= {count_snapshot, test_flag,
                                        early_warning_flag};
                ADDR_LOAD:  rdata_o <= load_value;
                ADDR_EARLY: rdata_o <= early_val;
                ADDR_WIN:   rdata_o <= win_val;
                ADDR_LOCK:  rdata_o <= {lock_active, 15'h0000};
                ADDR_ID0:   rdata_o <= {CONFIG_NUM, PART_NUM};
                ADDR_ID1:   rdata_o <= {RSVD_NUM, MINOR_REV, MAJOR_REV};
                default:    rdata_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence unlock_s;
        unlock_hit;
    endsequence

    sequence guarded_wr_s;
        prot_wr;
    endsequence

    sequence reg_last_s;
        lock_wr && seq == WWD_SEQ_KEY0 && key_bit && code_in == pend_code;
    endsequence

    timeout_outputs_a: assert property (
        cnt.expire |=> wdt_irq_o && sys_rst_o)
        else $error("timeout without irq and reset");

    window_reset_a: assert property (
        win_viol |=> sys_rst_o && !wdt_irq_o [*1])
        else $error("early reload did not reset");

    single_grant_a: assert property (
        unlock_s ##[1:2] guarded_wr_s |=> !grant)
        else $error("grant outlived one write");

    locked_ignore_a: assert property (
        prot_wr && lock_active && !grant && addr_i == ADDR_LOAD
        |=> load_value == $past(load_value) && !cnt.reload)
        else $error("protected write went through");

    free_write_a: assert property (
        !lock_active && wr_i && addr_i == ADDR_WIN |=> win_val == $past(wdata_i))
        else $error("unlocked write lost");

    lock_status_a: assert property (
        reg_last_s ##[1:2] (rd_i && addr_i == ADDR_LOCK) |=> rdata_o[LOCK_KEY])
        else $error("lock status not shown");

    early_flag_a: assert property (
        cnt.early && early_warning_irq_enable |=> early_warning_flag ##1 early_irq_o)
        else $error("early warning missed");

    test_flag_a: assert property (
        cnt.expire && test_enable |=> test_flag ##1 test_irq_o)
        else $error("test interrupt missed");

    count_read_a: assert property (
        sts_rd |=> rdata_o[15:2] == $past(count_snapshot))
        else $error("status count mismatch");

    id_read_a: assert property (
        rd_i && addr_i == ADDR_ID0 |=> rdata_o == {CONFIG_NUM, PART_NUM})
        else $error("identification read wrong");
endmodule

`default_nettype wire

/* logic/wwd_pkg.sv */
// package: watchdog register map, field positions and reset values
`default_nettype none

package wwd_pkg;
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 8;
    localparam int          CNT_W       = 16;
    localparam int          PRESC_W     = 12;
    // byte addresses of the registers
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STS    = 8'h04;
    localparam logic [7:0]  ADDR_LOAD   = 8'h08;
    localparam logic [7:0]  ADDR_EARLY  = 8'h0c;
    localparam logic [7:0]  ADDR_WIN    = 8'h10;
    localparam logic [7:0]  ADDR_LOCK   = 8'h14;
    localparam logic [7:0]  ADDR_ID0    = 8'h18;
    localparam logic [7:0]  ADDR_ID1    = 8'h1c;
    // control field positions
    localparam int          CTRL_RUN    = 0;
    localparam int          CTRL_EWI    = 1;
    localparam int          CTRL_WIN    = 2;
    localparam int          CTRL_TEST   = 3;
    localparam int          CTRL_EXP_LO = 4;
    localparam int          CTRL_EXP_HI = 7;
    localparam logic [3:0]  EXP_MAX     = 4'hc;
    // status and lock field positions
    localparam int          STS_EARLY   = 0;
    localparam int          STS_TEST    = 1;
    localparam int          STS_CNT_LO  = 2;
    localparam int          LOCK_KEY    = 15;
    // values after reset
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] LOAD_RESET  = 16'hffff;
    localparam logic [15:0] EARLY_RESET = 16'h0000;
    localparam logic [15:0] WIN_RESET   = 16'hffff;
    localparam logic [14:0] CODE_RESET  = 15'h0000;

    // lock code registration sequence
    typedef enum logic [1:0] {
        WWD_SEQ_IDLE = 2'b00,
        WWD_SEQ_KEY1 = 2'b01,
        WWD_SEQ_KEY0 = 2'b11
    } wwd_seq_e;
endpackage

`default_nettype wire

/* logic/wwd_cnt_if.sv */
// interface: control and status between register file and down counter
`default_nettype none

interface wwd_cnt_if;
    logic        run;
    logic        reload;
    logic        tick;
    logic [3:0]  exp;
    logic [15:0] load_val;
    logic [15:0] early_val;
    logic [15:0] count;
    logic        expire;
    logic        early;

    modport ctrl (output run, reload, tick, exp, load_val, early_val,
                  input count, expire, early);
    modport counter (input run, reload, tick, exp, load_val, early_val,
                     output count, expire, early);
endinterface

`default_nettype wire

/* logic/wwd_edge_sync.sv */
// synchroniser and rising-edge detector for the counter clock pin
`default_nettype none

module wwd_edge_sync (
    input  wire logic clk_i,     // system clock
    input  wire logic rst_i,     // async reset, high
    input  wire logic async_i,   // counter clock pin
    output logic      rise_o     // one pulse per rising edge
);
    logic meta;
    logic stable;
    logic prev;

    // two-flop synchroniser, then edge detect on the stable copy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            meta   <= async_i;
            stable <= meta;
            prev   <= stable;
            rise_o <= stable & ~prev;
        end
    end

    rise_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rise_o |=> !rise_o) else $error("tick pulse longer than one cycle");
endmodule

`default_nettype wire

/* logic/wwd_counter.sv */
// prescaled down counter with expiry and early warning pulses
`default_nettype none

module wwd_counter (
    input  wire logic  clk_i,   // system clock
    input  wire logic  rst_i,   // async reset, high
    wwd_cnt_if.counter cnt      // control from register file
);
    import wwd_pkg::*;

    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] mask;
    logic               step;
    logic               at_zero;

    // divide mask 2^n - 1 for the selected exponent
    assign mask    = PRESC_W'((13'h0001 << cnt.exp) - 13'h0001);
    assign step    = cnt.tick && ((presc & mask) == mask);
    assign at_zero = (cnt.count == '0);

    // halted counter holds the load value so a restart begins there
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc     <= '0;
            cnt.count <= LOAD_RESET;
        end else if (!cnt.run || cnt.reload) begin
            presc     <= '0;
            cnt.count <= cnt.load_val;
        end else if (step) begin
            presc     <= '0;
            cnt.count <= at_zero ? cnt.load_val : cnt.count - 16'h0001;
        end else if (cnt.tick) begin
            presc     <= presc + 12'h001;
        end
    end

    // event pulses on the counting step
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt.expire <= 1'b0;
            cnt.early  <= 1'b0;
        end else begin
            cnt.expire <= cnt.run && !cnt.reload && step && at_zero;
            cnt.early  <= cnt.run && !cnt.reload && step && !at_zero
                          && (cnt.count - 16'h0001 == cnt.early_val);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    halt_hold_a: assert property (
        !cnt.run |=> cnt.count == $past(cnt.load_val) && !cnt.expire)
        else $error("halted counter moved");
    restart_load_a: assert property (
        $rose(cnt.run) |-> cnt.count == $past(cnt.load_val))
        else $error("restart not from load value");
endmodule

`default_nettype wire

/* bench/wwd_top_tb.sv */
// bench: self-checking testbench with a behavioural model of the watchdog
`default_nettype none

module wwd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wwd_pkg::*;

    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic        cnt_clk_i = 1'b0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [7:0]  addr_i    = 8'h00;
    logic [15:0] wdata_i   = 16'h0000;
    logic [15:0] rdata_o;
    logic        wdt_irq_o;
    logic        sys_rst_o;
    logic        early_irq_o;
    logic        test_irq_o;
    int          n_fail      = 0;
    int          comparisons = 0;
    int          n_irq       = 0;
    int          n_rst       = 0;
    // model state: registers, count, prescaler, flags, events
    int          m_ctrl = 0, m_load = 'hffff, m_early = 0, m_win = 'hffff;
    int          m_cnt = 'hffff, m_pre = 0, m_fe = 0, m_ft = 0, m_exp = 0, m_viol = 0;
    logic [31:0] seed   = 32'd13;
    logic [14:0] code;

    wwd_top u_dut (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .cnt_clk_i   (cnt_clk_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .wr_i        (wr_i),
        .rd_i        (rd_i),
        .rdata_o     (rdata_o),
        .wdt_irq_o   (wdt_irq_o),
        .sys_rst_o   (sys_rst_o),
        .early_irq_o (early_irq_o),
        .test_irq_o  (test_irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and pulse counters for the one-cycle outputs
    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (wdt_irq_o === 1'b1) n_irq <= n_irq + 1;
        if (sys_rst_o === 1'b1) n_rst <= n_rst + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers: random source, compare, bus cycles
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
        comparisons++;
        if (act !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, act);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(nm, exp, rdata_o);
    endtask

    // write that also updates the model
    task automatic mw(input logic [7:0] a, input logic [15:0] d);
        wr(a, d);
        case (a)
            ADDR_CTRL: begin
                m_ctrl = d[7:0];
                if (!d[0]) begin
                    m_cnt = m_load;
                    m_pre = 0;
                end
                if (!d[3]) m_ft = 0;
            end
            ADDR_LOAD: begin
                if (m_ctrl[2] && m_ctrl[0] && m_cnt > m_win) m_viol++;
                m_load = d;
                m_cnt  = d;
                m_pre  = 0;
            end
            ADDR_EARLY: m_early = d;
            ADDR_WIN:   m_win = d;
            default: ;
        endcase
    endtask

    // one counter clock edge, model step, then compare outputs and status
    task automatic tick();
        int ex;
        @(posedge clk_i);
        cnt_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        cnt_clk_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ex = (m_ctrl[7:4] > 12) ? 12 : m_ctrl[7:4];
        if (m_ctrl[0]) begin
            m_pre++;
            if (m_pre >= (1 << ex)) begin
                m_pre = 0;
                if (m_cnt == 0) begin
                    m_cnt = m_load;
                    m_exp++;
                    if (m_ctrl[3]) m_ft = 1;
                end else begin
                    m_cnt--;
                    if (m_ctrl[1] && m_cnt == m_early) m_fe = 1;
                end
            end
        end
        #1;
        chk("early_irq", 16'(m_fe), 16'(early_irq_o));
        chk("test_irq", 16'(m_ft), 16'(test_irq_o));
        chk("irq_pulses", 16'(m_exp), 16'(n_irq));
        chk("rst_pulses", 16'(m_exp + m_viol), 16'(n_rst));
        rc(ADDR_STS, 16'({m_cnt[15:2], m_ft[0], m_fe[0]}), "status");
        m_fe = 0;
        m_ft = 0;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard, far above the expected run length
    initial begin
        #200000;
        n_fail++;
        $display("BAD watchdog expected finish seen timeout");
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(ADDR_CTRL, 16'h0000, "ctrl");
        rc(ADDR_STS, 16'hfffc, "status");
        rc(ADDR_LOAD, 16'hffff, "load");
        rc(ADDR_EARLY, 16'h0000, "early");
        rc(ADDR_WIN, 16'hffff, "window");
        rc(ADDR_LOCK, 16'h0000, "lock");
        rc(ADDR_ID0, 16'h20a5, "id0");
        rc(ADDR_ID1, 16'h0003, "id1");
        rc(8'h20, 16'h0000, "unmapped");
        wr(ADDR_ID0, 16'h1234);
        wr(ADDR_STS, 16'h00ff);
        rc(ADDR_ID0, 16'h20a5, "id0_ro");
        rc(ADDR_STS, 16'hfffc, "status_ro");
        $display("test reset_values done");
        // random values through every writable register except lock, counter stopped
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            mw(ADDR_LOAD, seed[15:0]);
            mw(ADDR_EARLY, seed[31:16]);
            mw(ADDR_WIN, seed[15:0] ^ seed[31:16]);
            mw(ADDR_CTRL, {seed[22:8], 1'b0});
            rc(ADDR_CTRL, 16'(m_ctrl), "ctrl");
            rc(ADDR_LOAD, 16'(m_load), "load");
            rc(ADDR_EARLY, 16'(m_early), "early");
            rc(ADDR_WIN, 16'(m_win), "window");
            rc(ADDR_STS, {m_load[15:2], 2'b00}, "held_count");
        end
        mw(ADDR_CTRL, 16'h0000);
        mw(ADDR_EARLY, 16'h0000);
        $display("test register_rw done");
        mw(ADDR_LOAD, 16'h0006);
        mw(ADDR_CTRL, 16'h0001);
        repeat (8) tick();
        tick();
        mw(ADDR_CTRL, 16'h0000);
        tick();
        mw(ADDR_CTRL, 16'h0001);
        tick();
        $display("test expiry_halt done");
        mw(ADDR_CTRL, 16'h0021);
        repeat (9) tick();
        mw(ADDR_CTRL, 16'h00f1);
        repeat (2) tick();
        $display("test prescaler done");
        mw(ADDR_LOAD, 16'h0006);
        mw(ADDR_EARLY, 16'h0003);
        mw(ADDR_CTRL, 16'h000b);
        repeat (8) tick();
        $display("test early_and_test done");
        mw(ADDR_WIN, 16'h0002);
        mw(ADDR_CTRL, 16'h0005);
        mw(ADDR_LOAD, 16'h0006);
        repeat (4) tick();
        mw(ADDR_LOAD, 16'h0006);
        tick();
        $display("test window done");
        mw(ADDR_CTRL, 16'h0000);
        seed = xs(seed);
        code = seed[14:0];
        wr(ADDR_LOCK, {1'b1, code});
        wr(ADDR_LOCK, {1'b0, code});
        wr(ADDR_LOCK, {1'b1, code});
        rc(ADDR_LOCK, 16'h8000, "lock");
        wr(ADDR_EARLY, 16'h0055);
        rc(ADDR_EARLY, 16'(m_early), "early_locked");
        wr(ADDR_LOCK, {1'b0, code});
        wr(ADDR_EARLY, 16'h0077);
        rc(ADDR_EARLY, 16'h0077, "early_granted");
        wr(ADDR_EARLY, 16'h0099);
        rc(ADDR_EARLY, 16'h0077, "early_regrant");
        wr(ADDR_LOAD, 16'h0123);
        rc(ADDR_LOAD, 16'(m_load), "load_locked");
        $display("test lock done");
        test_done();
    end
endmodule

`default_nettype wire
